// file: bench/board_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// board side of the pads
// ****************************************************************
module board_model (
  input wire logic clock,
  input wire logic [4:0] pin_out,
  input wire logic [4:0] pin_oe,
  input wire logic pull_up,
  input wire logic pull_down,
  input wire logic [4:0] ext_level,
  input wire logic [4:0] ext_en,
  output logic [4:0] pin_in
);
  // a floating pad wanders so a stale level never passes for a drive
  logic wander_reg = 1'b0;
  always_ff @(posedge clock) begin
    wander_reg <= ~wander_reg;
  end
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      if (pin_oe[i]) begin
        pin_in[i] = pin_out[i];
      end else if (ext_en[i]) begin
        pin_in[i] = ext_level[i];
      end else begin
        pin_in[i] = wander_reg;
      end
    end
    if (!pin_oe[0] && !ext_en[0] && (pull_up || pull_down)) begin
      pin_in[0] = pull_up;
    end
  end
endmodule
`default_nettype wire

// file: bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock = 1'b0, rst = 1'b1, ser = 1'b0, sel = 1'b0, chip_on = 1'b1;
  logic [4:0][3:0] mode = {4'h7, 4'hF, 4'h8, 4'h1, 4'hE};
  logic [1:0][7:0] va = {8'h64, 8'h10}, vb = {8'hFF, 8'h50};
  logic [1:0][1:0] ma = {2'h3, 2'h1}, mb = {2'h2, 2'h0};
  logic [1:0] vsel = 2'b10, en_otp = 2'b00, good = 2'b01;
  logic irq = 1'b0, sda_low = 1'b1;
  logic [4:0] ext_level = 5'h00, ext_en = 5'h12, pin_in, pin_out, pin_oe;
  logic pu, pd, scl, sda, pulse;
  logic [1:0] step;
  logic [3:0] masks, omask = 4'h6;
  logic [1:0][3:0] ond, offd;
  logic [1:0] rail_en, pdn, idx;
  logic [1:0][7:0] tgt;
  logic [1:0][1:0] rmode;
  logic [6:0] addr;
  logic [2:0] free;
  int n_errors = 0, samples_checked = 0, reloads = 0;
  always #2 clock = ~clock;
  always @(posedge clock) if (pulse === 1'b1) reloads++;
  board_model board_u (.clock(clock), .pin_out(pin_out), .pin_oe(pin_oe),
    .pull_up(pu), .pull_down(pd), .ext_level(ext_level), .ext_en(ext_en),
    .pin_in(pin_in));
  // short filter keeps the reload scenarios brief
  pin_function_control #(.DEBOUNCE_CYCLES(4)) dut_u (.clock(clock),
    .rst(rst), .serial_if_option(ser), .cfg_select_option(sel),
    .chip_on_input(chip_on), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .cfg_probe_pull_up(pu), .cfg_probe_pull_down(pd),
    .otp_pin_mode(mode), .otp_slave_addr(7'h55),
    .otp_rail_voltage_code_a(va), .otp_rail_voltage_code_b(vb),
    .otp_rail_regulation_mode_a(ma), .otp_rail_regulation_mode_b(mb),
    .otp_rail_set_select(vsel), .otp_rail_enable(en_otp),
    .otp_status_masks(omask), .otp_on_delay(8'h00), .otp_off_delay(8'h00),
    .rail_good(good), .system_ok(1'b1), .interrupt_request(irq),
    .i2c_sda_pull_low(sda_low), .i2c_scl_level(scl), .i2c_sda_level(sda),
    .rail_enable(rail_en), .rail_voltage_step(step),
    .switch_node_pulldown(pdn),
    .rail_target_code(tgt), .rail_regulation_mode(rmode),
    .slave_addr(addr), .status_masks(masks), .on_delay(ond),
    .off_delay(offd),
    .cfg_index(idx), .free_pin_count(free), .reload_pulse(pulse));
  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic check(string name, logic [15:0] exp, logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic settle(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic end_of_test();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    settle(20);
    @(posedge clock) rst <= 1'b0;
    settle(30); // settings apply after two edges, margin for start-up
    check("free", 16'h5, free);
    check("oe", 16'h0D, pin_oe);
    check("out", 16'h0C, pin_out);
    check("tgt", 16'hBE1E, tgt);
    check("rmode", 16'h9, rmode);
    check("masks", 16'h6, masks);
    @(posedge clock) ext_level <= 5'h02;
    settle(2);
    check("en", 16'h1, rail_en);
    @(posedge clock) good <= 2'b00;
    chip_on <= 1'b0;
    settle(2);
    check("good", 16'h0, pin_out[2]);
    check("off", 16'h0, rail_en);
    check("pdn", 16'h3, pdn);
    @(posedge clock) chip_on <= 1'b1;
    va <= {8'h96, 8'h05};
    vb <= {8'h00, 8'h50};
    vsel <= 2'b01;
    ext_level <= 5'h12;
    settle(2);
    @(posedge clock) ext_level <= 5'h02;
    settle(10);
    check("short", 16'h0, 16'(reloads));
    @(posedge clock) ext_level <= 5'h12;
    settle(20);
    check("reload", 16'h1, 16'(reloads));
    check("tgt2", 16'h9650, tgt);
    check("rmode2", 16'hC, rmode);
    check("keep", 16'h1, rail_en);
    @(posedge clock) ext_level <= 5'h02;
    settle(20);
    check("fall", 16'h1, 16'(reloads));
    @(posedge clock) ser <= 1'b1;
    settle(2);
    check("free3", 16'h3, free);
    @(posedge clock) rst <= 1'b1;
    ser <= 1'b1;
    sel <= 1'b1;
    ext_en <= 5'h08;
    ext_level <= 5'h00;
    settle(20);
    @(posedge clock) rst <= 1'b0;
    settle(40); // probe takes 23 edges before run
    check("free2", 16'h2, free);
    check("idx", 16'h2, idx);
    check("addr", 16'h12, addr);
    check("tgt3", 16'h3232, tgt);
    check("oe2", 16'h14, pin_oe);
    check("out2", 16'h1, {pin_out[4], pin_out[2]});
    check("scl", 16'h0, scl);
    @(posedge clock) irq <= 1'b1;
    sda_low <= 1'b0;
    settle(2);
    check("irq", 16'h0, pin_out[2]);
    check("sda", 16'h0, pin_oe[4]);
    // selector now held high by the board, so the high preset applies
    @(posedge clock) rst <= 1'b1;
    ext_en <= 5'h1B;
    ext_level <= 5'h13;
    good <= 2'b11;
    settle(20);
    @(posedge clock) rst <= 1'b0;
    settle(40);
    check("idx3", 16'h1, idx);
    check("addr3", 16'h11, addr);
    check("tgt4", 16'h7878, tgt);
    check("en3", 16'h3, rail_en);
    check("masks3", 16'hF, masks);
    check("dly3", 16'h1111, {ond, offd});
    check("step", 16'h3, step);
    check("good3", 16'h1, pin_out[2]);
    check("sda3", 16'h1, sda);
    end_of_test();
  end
endmodule
`default_nettype wire

// file: hw/pin_function_control.sv
`timescale 1ns/1ps
`default_nettype none

module pin_function_control #(
  parameter int unsigned DEBOUNCE_CYCLES = pin_function_pkg::DEBOUNCE_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic serial_if_option,
  input wire logic cfg_select_option,
  input wire logic chip_on_input,
  input wire logic [4:0] pin_in,
  output logic [4:0] pin_out,
  output logic [4:0] pin_oe,
  output logic cfg_probe_pull_up,
  output logic cfg_probe_pull_down,
  input wire logic [4:0][3:0] otp_pin_mode,
  input wire logic [6:0] otp_slave_addr,
  input wire logic [1:0][7:0] otp_rail_voltage_code_a,
  input wire logic [1:0][7:0] otp_rail_voltage_code_b,
  input wire logic [1:0][1:0] otp_rail_regulation_mode_a,
  input wire logic [1:0][1:0] otp_rail_regulation_mode_b,
  input wire logic [1:0] otp_rail_set_select,
  input wire logic [1:0] otp_rail_enable,
  input wire logic [3:0] otp_status_masks,
  input wire logic [1:0][3:0] otp_on_delay,
  input wire logic [1:0][3:0] otp_off_delay,
  input wire logic [1:0] rail_good,
  input wire logic system_ok,
  input wire logic interrupt_request,
  input wire logic i2c_sda_pull_low,
  output logic i2c_scl_level,
  output logic i2c_sda_level,
  output logic [1:0] rail_enable,
  output logic [1:0] rail_voltage_step,
  output logic [1:0] switch_node_pulldown,
  output logic [1:0][7:0] rail_target_code,
  output logic [1:0][1:0] rail_regulation_mode,
  output logic [6:0] slave_addr,
  output logic [3:0] status_masks,
  output logic [1:0][3:0] on_delay,
  output logic [1:0][3:0] off_delay,
  output logic [1:0] cfg_index,
  output logic [2:0] free_pin_count,
  output logic reload_pulse
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  pin_function_pkg::setup_state_t state_reg;
  logic [3:0] probe_cnt_reg;
  logic sample_high_reg;
  logic sample_low_reg;
  logic [1:0] cfg_index_reg;
  logic [1:0] cfg_index_next;
  pin_function_pkg::preset_t otp_set;
  pin_function_pkg::preset_t src_set;
  logic load_all;
  logic load_settings;
  logic [4:0][3:0] pin_mode_reg;
  logic [4:0][3:0] eff_mode;
  logic [1:0][7:0] volt_a_reg;
  logic [1:0][7:0] volt_b_reg;
  logic [1:0][1:0] mode_a_reg;
  logic [1:0][1:0] mode_b_reg;
  logic [1:0] set_sel_reg;
  logic [1:0] rail_en_reg;
  logic [1:0] on_req;
  logic [1:0] step_req;
  logic reload_raw;
  logic [4:0] drive;
  logic [4:0] level;
  logic reload_stable_reg;
  logic [pin_function_pkg::DEB_CNT_W-1:0] deb_cnt_reg;
  logic [1:0][7:0] chosen_code;
  logic [2:0] free_pin_next;

  // ****************************************************************
  // selector probe and preset choice
  // ****************************************************************
  // pin 0 is probed with a weak pull each way: if it follows both
  // pulls nothing drives it, so the pin is open
  always_comb begin
    unique case ({sample_high_reg, sample_low_reg})
      2'b11: cfg_index_next = pin_function_pkg::CFG_HIGH;
      2'b10: cfg_index_next = pin_function_pkg::CFG_OPEN;
      default: cfg_index_next = pin_function_pkg::CFG_LOW;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= pin_function_pkg::ST_PROBE_HIGH;
      probe_cnt_reg <= 4'h0;
      sample_high_reg <= 1'b0;
      sample_low_reg <= 1'b0;
      cfg_index_reg <= pin_function_pkg::CFG_LOW;
    end else begin
      unique case (state_reg)
        pin_function_pkg::ST_PROBE_HIGH: begin
          if (!cfg_select_option) begin
            state_reg <= pin_function_pkg::ST_APPLY;
          end else if (probe_cnt_reg == pin_function_pkg::PROBE_CYCLES) begin
            sample_high_reg <= pin_in[0];
            probe_cnt_reg <= 4'h0;
            state_reg <= pin_function_pkg::ST_PROBE_LOW;
          end else begin
            probe_cnt_reg <= probe_cnt_reg + 4'h1;
          end
        end
        pin_function_pkg::ST_PROBE_LOW: begin
          if (probe_cnt_reg == pin_function_pkg::PROBE_CYCLES) begin
            sample_low_reg <= pin_in[0];
            probe_cnt_reg <= 4'h0;
            state_reg <= pin_function_pkg::ST_APPLY;
          end else begin
            probe_cnt_reg <= probe_cnt_reg + 4'h1;
          end
        end
        pin_function_pkg::ST_APPLY: begin
          cfg_index_reg <= cfg_index_next;
          state_reg <= pin_function_pkg::ST_RUN;
        end
        pin_function_pkg::ST_RUN: begin
          state_reg <= pin_function_pkg::ST_RUN;
        end
      endcase
    end
  end

  assign cfg_probe_pull_up = (state_reg == pin_function_pkg::ST_PROBE_HIGH)
    && cfg_select_option;
  assign cfg_probe_pull_down = (state_reg == pin_function_pkg::ST_PROBE_LOW);
  assign cfg_index = cfg_index_reg;

  // ****************************************************************
  // configuration store
  // ****************************************************************
  always_comb begin
    otp_set.slave_addr = otp_slave_addr;
    otp_set.volt_a = otp_rail_voltage_code_a;
    otp_set.volt_b = otp_rail_voltage_code_b;
    otp_set.mode_a = otp_rail_regulation_mode_a;
    otp_set.mode_b = otp_rail_regulation_mode_b;
    otp_set.set_sel = otp_rail_set_select;
    otp_set.rail_en = otp_rail_enable;
    otp_set.status_masks = otp_status_masks;
    otp_set.on_delay = otp_on_delay;
    otp_set.off_delay = otp_off_delay;
    otp_set.pin1_mode = otp_pin_mode[1];
    otp_set.pin2_mode = otp_pin_mode[2];
    if (!cfg_select_option) begin
      src_set = otp_set;
    end else if (state_reg == pin_function_pkg::ST_APPLY) begin
      src_set = pin_function_pkg::PRESETS[cfg_index_next];
    end else begin
      src_set = pin_function_pkg::PRESETS[cfg_index_reg];
    end
  end

  assign load_all = (state_reg == pin_function_pkg::ST_APPLY);
  // one shared strobe loads both rails in the same cycle
  assign load_settings = load_all ||
    ((state_reg == pin_function_pkg::ST_RUN) && reload_pulse);

  always_ff @(posedge clock) begin
    if (rst) begin
      volt_a_reg <= '0;
      volt_b_reg <= '0;
      mode_a_reg <= '0;
      mode_b_reg <= '0;
      set_sel_reg <= '0;
    end else if (load_settings) begin
      volt_a_reg <= src_set.volt_a;
      volt_b_reg <= src_set.volt_b;
      mode_a_reg <= src_set.mode_a;
      mode_b_reg <= src_set.mode_b;
      set_sel_reg <= src_set.set_sel;
    end
  end

  // enables, masks, delays and pin roles are not part of a reload
  always_ff @(posedge clock) begin
    if (rst) begin
      rail_en_reg <= '0;
      slave_addr <= '0;
      status_masks <= '0;
      on_delay <= '0;
      off_delay <= '0;
      pin_mode_reg <= '0;
    end else if (load_all) begin
      rail_en_reg <= src_set.rail_en;
      slave_addr <= src_set.slave_addr;
      status_masks <= src_set.status_masks;
      on_delay <= src_set.on_delay;
      off_delay <= src_set.off_delay;
      pin_mode_reg <= otp_pin_mode;
      pin_mode_reg[1] <= src_set.pin1_mode;
      pin_mode_reg[2] <= src_set.pin2_mode;
    end
  end

  // ****************************************************************
  // pin roles
  // ****************************************************************
  always_comb begin
    eff_mode = pin_mode_reg;
    if (state_reg != pin_function_pkg::ST_RUN) begin
      eff_mode = '0;
    end
    if (cfg_select_option) begin
      eff_mode[0] = pin_function_pkg::MODE_OFF;
    end
    if (serial_if_option) begin
      eff_mode[3] = pin_function_pkg::MODE_OFF;
      eff_mode[4] = pin_function_pkg::MODE_OFF;
    end
  end

  always_comb begin
    on_req = '0;
    step_req = '0;
    reload_raw = 1'b0;
    drive = '0;
    level = '0;
    for (int p = 0; p < pin_function_pkg::NUM_PINS; p++) begin
      unique case (eff_mode[p])
        pin_function_pkg::MODE_ON_ONE: on_req[0] |= pin_in[p];
        pin_function_pkg::MODE_ON_TWO: on_req[1] |= pin_in[p];
        pin_function_pkg::MODE_ON_BOTH: on_req |= {2{pin_in[p]}};
        pin_function_pkg::MODE_STEP_ONE: step_req[0] |= pin_in[p];
        pin_function_pkg::MODE_STEP_TWO: step_req[1] |= pin_in[p];
        pin_function_pkg::MODE_STEP_BOTH: step_req |= {2{pin_in[p]}};
        pin_function_pkg::MODE_RELOAD: reload_raw |= pin_in[p];
        pin_function_pkg::MODE_GOOD_ONE: begin
          drive[p] = 1'b1;
          level[p] = rail_good[0];
        end
        pin_function_pkg::MODE_GOOD_TWO: begin
          drive[p] = 1'b1;
          level[p] = rail_good[1];
        end
        pin_function_pkg::MODE_GOOD_BOTH: begin
          drive[p] = 1'b1;
          level[p] = &rail_good;
        end
        pin_function_pkg::MODE_SYSTEM_OK: begin
          drive[p] = 1'b1;
          level[p] = system_ok;
        end
        pin_function_pkg::MODE_IRQ: begin
          drive[p] = 1'b1;
          level[p] = ~interrupt_request;
        end
        pin_function_pkg::MODE_DRIVE_LOW: drive[p] = 1'b1;
        pin_function_pkg::MODE_DRIVE_HIGH: begin
          drive[p] = 1'b1;
          level[p] = 1'b1;
        end
        default: drive[p] = 1'b0;
      endcase
    end
  end

  // the serial data line is open drain: only ever pulled low
  always_ff @(posedge clock) begin
    if (rst) begin
      pin_out <= '0;
      pin_oe <= '0;
      i2c_scl_level <= 1'b1;
      i2c_sda_level <= 1'b1;
    end else begin
      pin_out <= level;
      pin_oe <= drive;
      i2c_scl_level <= serial_if_option ? pin_in[3] : 1'b1;
      i2c_sda_level <= serial_if_option ? pin_in[4] : 1'b1;
      if (serial_if_option) begin
        pin_oe[4] <= i2c_sda_pull_low;
        pin_out[4] <= 1'b0;
      end
    end
  end

  always_comb begin
    free_pin_next = pin_function_pkg::PINS_ALL;
    if (serial_if_option) begin
      free_pin_next = free_pin_next - pin_function_pkg::PINS_SERIAL_TAKEN;
    end
    if (cfg_select_option) begin
      free_pin_next = free_pin_next - pin_function_pkg::PINS_SELECT_TAKEN;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      free_pin_count <= pin_function_pkg::PINS_ALL;
    end else begin
      free_pin_count <= free_pin_next;
    end
  end

  // ****************************************************************
  // reload trigger filter
  // ****************************************************************
  // a level must hold a full filter time before it counts, so a
  // bouncing contact gives one reload, at the cost of that latency
  always_ff @(posedge clock) begin
    if (rst) begin
      deb_cnt_reg <= '0;
      reload_stable_reg <= 1'b0;
    end else if (reload_raw == reload_stable_reg) begin
      deb_cnt_reg <= '0;
    end else if (deb_cnt_reg ==
                 pin_function_pkg::DEB_CNT_W'(DEBOUNCE_CYCLES - 1)) begin
      deb_cnt_reg <= '0;
      reload_stable_reg <= reload_raw;
    end else begin
      deb_cnt_reg <= deb_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      reload_pulse <= 1'b0;
    end else begin
      reload_pulse <= reload_raw && !reload_stable_reg && (deb_cnt_reg ==
        pin_function_pkg::DEB_CNT_W'(DEBOUNCE_CYCLES - 1));
    end
  end

  // ****************************************************************
  // rail outputs
  // ****************************************************************
  always_comb begin
    for (int r = 0; r < pin_function_pkg::NUM_RAILS; r++) begin
      chosen_code[r] = set_sel_reg[r] ? volt_b_reg[r] : volt_a_reg[r];
    end
  end

  // enables ignore reload, so a rail keeps regulating through it
  always_ff @(posedge clock) begin
    if (rst) begin
      rail_enable <= '0;
      rail_voltage_step <= '0;
      switch_node_pulldown <= 2'h3;
      rail_target_code <= {2{pin_function_pkg::VOLT_MIN_CODE}};
      rail_regulation_mode <= '0;
    end else begin
      rail_enable <= (rail_en_reg | on_req) & {2{chip_on_input}};
      rail_voltage_step <= step_req;
      switch_node_pulldown <= {2{~chip_on_input}};
      for (int r = 0; r < pin_function_pkg::NUM_RAILS; r++) begin
        if (chosen_code[r] < pin_function_pkg::VOLT_MIN_CODE) begin
          rail_target_code[r] <= pin_function_pkg::VOLT_MIN_CODE;
        end else if (chosen_code[r] > pin_function_pkg::VOLT_MAX_CODE) begin
          rail_target_code[r] <= pin_function_pkg::VOLT_MAX_CODE;
        end else begin
          rail_target_code[r] <= chosen_code[r];
        end
        // codes pass through unchanged: 0 PFM .. 3 auto
        rail_regulation_mode[r] <= set_sel_reg[r] ?
          mode_b_reg[r] : mode_a_reg[r];
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence probed_open_s;
    load_all && cfg_select_option && sample_high_reg && !sample_low_reg;
  endsequence
  sequence probed_high_s;
    load_all && cfg_select_option && sample_high_reg && sample_low_reg;
  endsequence

  select_open_a: assert property (probed_open_s |=>
    cfg_index == pin_function_pkg::CFG_OPEN)
    else $error("open selector not mapped to open preset");
  select_high_a: assert property (probed_high_s |=>
    cfg_index == pin_function_pkg::CFG_HIGH)
    else $error("high selector not mapped to high preset");
  preset_addr_a: assert property (probed_open_s |=>
    slave_addr == pin_function_pkg::PRESETS[pin_function_pkg::CFG_OPEN]
      .slave_addr)
    else $error("preset address not applied");
  pin_count_a: assert property (serial_if_option &&
    !cfg_select_option |=> free_pin_count == 3'h3)
    else $error("wrong free pin count with serial on");
  serial_clock_a: assert property (serial_if_option |=>
    !pin_oe[3] && i2c_scl_level == $past(pin_in[3]))
    else $error("serial clock pin misrouted");
  selector_float_a: assert property (cfg_select_option |=>
    !pin_oe[0])
    else $error("selector pin driven");
  drive_low_a: assert property (eff_mode[0] ==
    pin_function_pkg::MODE_DRIVE_LOW |=> pin_oe[0] && !pin_out[0])
    else $error("low level code not driving low");
  reserved_float_a: assert property (eff_mode[2] ==
    pin_function_pkg::MODE_RESERVED || eff_mode[2] ==
    pin_function_pkg::MODE_OFF |=> !pin_oe[2])
    else $error("reserved code drives pin");
  enable_input_a: assert property (eff_mode[1] ==
    pin_function_pkg::MODE_ON_ONE && pin_in[1] && chip_on_input
    |=> rail_enable[0])
    else $error("enable pin did not turn rail on");
  good_out_a: assert property (eff_mode[2] ==
    pin_function_pkg::MODE_GOOD_ONE |=> pin_oe[2] &&
    pin_out[2] == $past(rail_good[0]))
    else $error("rail one good not on pin");
  irq_out_a: assert property (eff_mode[2] ==
    pin_function_pkg::MODE_IRQ && interrupt_request |=> pin_oe[2] &&
    !pin_out[2])
    else $error("interrupt not driven low");
  chip_off_a: assert property (!chip_on_input |=>
    rail_enable == 2'h0 && switch_node_pulldown == 2'h3)
    else $error("rails alive while chip off");
  reload_once_a: assert property (reload_pulse |=>
    (!reload_pulse)[*2])
    else $error("reload pulse repeated");
  reload_cause_a: assert property ($changed(volt_a_reg) ||
    $changed(set_sel_reg) |-> $past(load_settings))
    else $error("settings changed without load");
  clamp_a: assert property (rail_target_code[0] >=
    pin_function_pkg::VOLT_MIN_CODE && rail_target_code[1] <=
    pin_function_pkg::VOLT_MAX_CODE && rail_target_code[0] <=
    pin_function_pkg::VOLT_MAX_CODE && rail_target_code[1] >=
    pin_function_pkg::VOLT_MIN_CODE)
    else $error("target code outside range");

endmodule

`default_nettype wire

// file: hw/pin_function_pkg.sv
package pin_function_pkg;

  // ****************************************************************
  // sizes and clock
  // ****************************************************************
  localparam int NUM_PINS = 5;
  localparam int NUM_RAILS = 2;
  localparam int CLOCK_PERIOD_NS = 4;
  localparam int DEB_CNT_W = 16;

  // input filter on the settings-reload pin, least time so round up
  localparam int RELOAD_DEBOUNCE_US = 100;
  localparam int DEBOUNCE_CYCLES =
    (RELOAD_DEBOUNCE_US * 1000 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  // settle time of the weak pull while probing the select pin
  localparam int PROBE_SETTLE_NS = 40;
  localparam logic [3:0] PROBE_CYCLES =
    4'((PROBE_SETTLE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);

  // ****************************************************************
  // pin function codes
  // ****************************************************************
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_ON_ONE = 4'h1;
  localparam logic [3:0] MODE_ON_TWO = 4'h2;
  localparam logic [3:0] MODE_ON_BOTH = 4'h3;
  localparam logic [3:0] MODE_STEP_ONE = 4'h4;
  localparam logic [3:0] MODE_STEP_TWO = 4'h5;
  localparam logic [3:0] MODE_STEP_BOTH = 4'h6;
  localparam logic [3:0] MODE_RELOAD = 4'h7;
  localparam logic [3:0] MODE_GOOD_ONE = 4'h8;
  localparam logic [3:0] MODE_GOOD_TWO = 4'h9;
  localparam logic [3:0] MODE_GOOD_BOTH = 4'hA;
  localparam logic [3:0] MODE_SYSTEM_OK = 4'hB;
  localparam logic [3:0] MODE_IRQ = 4'hC;
  localparam logic [3:0] MODE_RESERVED = 4'hD;
  localparam logic [3:0] MODE_DRIVE_LOW = 4'hE;
  localparam logic [3:0] MODE_DRIVE_HIGH = 4'hF;

  // regulation modes and voltage code limits
  localparam logic [1:0] REG_FORCED_PFM = 2'h0;
  localparam logic [1:0] REG_FORCED_PWM_FULL = 2'h1;
  localparam logic [1:0] REG_FORCED_PWM_SHED = 2'h2;
  localparam logic [1:0] REG_AUTO = 2'h3;
  localparam int VOLT_STEP_MV = 10;
  localparam int VOLT_MIN_MV = 300;
  localparam int VOLT_MAX_MV = 1900;
  localparam logic [7:0] VOLT_MIN_CODE = 8'(VOLT_MIN_MV / VOLT_STEP_MV);
  localparam logic [7:0] VOLT_MAX_CODE = 8'(VOLT_MAX_MV / VOLT_STEP_MV);

  // available pin counts
  localparam logic [2:0] PINS_ALL = 3'h5;
  localparam logic [2:0] PINS_SERIAL_TAKEN = 3'h2;
  localparam logic [2:0] PINS_SELECT_TAKEN = 3'h1;

  // ****************************************************************
  // configuration presets
  // ****************************************************************
  localparam logic [1:0] CFG_LOW = 2'h0;
  localparam logic [1:0] CFG_HIGH = 2'h1;
  localparam logic [1:0] CFG_OPEN = 2'h2;

  typedef enum {ST_PROBE_HIGH, ST_PROBE_LOW, ST_APPLY, ST_RUN} setup_state_t;

  typedef struct packed {
    logic [6:0] slave_addr;
    logic [1:0][7:0] volt_a;
    logic [1:0][7:0] volt_b;
    logic [1:0][1:0] mode_a;
    logic [1:0][1:0] mode_b;
    logic [1:0] set_sel;
    logic [1:0] rail_en;
    logic [3:0] status_masks;
    logic [1:0][3:0] on_delay;
    logic [1:0][3:0] off_delay;
    logic [3:0] pin1_mode;
    logic [3:0] pin2_mode;
  } preset_t;

  localparam preset_t PRESETS [3] = '{
    '{slave_addr: 7'h10, volt_a: 16'h5A5A, volt_b: 16'h6464,
      mode_a: 4'hF, mode_b: 4'h5, set_sel: 2'h0, rail_en: 2'h0,
      status_masks: 4'h0, on_delay: 8'h00, off_delay: 8'h00,
      pin1_mode: 4'h1, pin2_mode: 4'h2},
    '{slave_addr: 7'h11, volt_a: 16'h7878, volt_b: 16'h8282,
      mode_a: 4'hF, mode_b: 4'hA, set_sel: 2'h0, rail_en: 2'h3,
      status_masks: 4'hF, on_delay: 8'h11, off_delay: 8'h11,
      pin1_mode: 4'h6, pin2_mode: 4'hA},
    '{slave_addr: 7'h12, volt_a: 16'h3232, volt_b: 16'h4646,
      mode_a: 4'h0, mode_b: 4'hF, set_sel: 2'h0, rail_en: 2'h0,
      status_masks: 4'h0, on_delay: 8'h22, off_delay: 8'h22,
      pin1_mode: 4'h7, pin2_mode: 4'hC}
  };

endpackage
